// ### hw/flm_addr_dec.sv
// flm global address decoder for flash, info rows and scratch ram
// assumes the address is stable for the whole access
`timescale 1ns/1ns
`include "flm_defs.svh"
module flm_addr_dec #(
  parameter int LOW_SIZE = 16384,
  parameter int HIGH_SIZE = 16384
) (
  flm_dec_if.dec d
);
  localparam flm_pkg::flm_gaddr_t LOW_END = 23'(`FLM_LOW_BASE + LOW_SIZE);
  localparam flm_pkg::flm_gaddr_t HIGH_BEG = 23'(`FLM_PFL_TOP - HIGH_SIZE + 1);
  initial begin
    if (LOW_SIZE < 0 || HIGH_SIZE < 0 || LOW_SIZE + HIGH_SIZE > 32768)
      $error("protection region sizes overlap");
  end
  wire in_pfl = d.addr >= `FLM_PFL_BASE;
  wire in_key = d.addr >= `FLM_KEY_BASE && d.addr <= `FLM_KEY_LAST;
  wire in_rsv = d.addr > `FLM_KEY_LAST && d.addr <= `FLM_CFG_RSVL;
  wire in_id = d.addr >= `FLM_ID_BASE && d.addr <= `FLM_ID_LAST;
  wire in_ver = d.addr >= `FLM_VER_BASE && d.addr <= `FLM_VER_LAST;
  wire in_once = d.addr >= `FLM_ONCE_BASE && d.addr <= `FLM_ONCE_LAST;
  wire in_low = in_pfl && d.addr >= `FLM_LOW_BASE && d.addr < LOW_END;
  wire in_high = in_pfl && d.addr >= HIGH_BEG;
  wire in_rem = in_pfl && !in_low && !in_high;
  // info and ram windows gated by visibility, hidden ones select nothing
  assign d.pfl = in_pfl;
  assign d.dfl = d.addr >= `FLM_DFL_BASE && d.addr <= `FLM_DFL_LAST;
  assign d.pifr = d.pifr_vis && (in_id || in_ver || in_once);
  assign d.difr = d.difr_vis && d.addr >= `FLM_DIFR_BASE
    && d.addr <= `FLM_DIFR_LAST;
  assign d.ram = d.ram_vis && d.addr >= `FLM_RAM_BASE
    && d.addr <= `FLM_RAM_LAST;
  assign d.wr_en = d.write && (d.pfl || d.dfl || d.pifr || d.difr || d.ram);
  assign d.prot_hit = d.write && ((in_low && d.prot_act[0])
    || (in_high && d.prot_act[1]) || (in_rem && d.prot_act[2]));
  // config field byte classification
  assign d.field = in_key ? flm_pkg::FLM_CF_KEY :
    in_rsv ? flm_pkg::FLM_CF_RSVD :
    d.addr == `FLM_CFG_PPROT ? flm_pkg::FLM_CF_PPROT :
    d.addr == `FLM_CFG_DPROT ? flm_pkg::FLM_CF_DPROT :
    d.addr == `FLM_CFG_OPT ? flm_pkg::FLM_CF_OPT :
    d.addr == `FLM_CFG_SEC ? flm_pkg::FLM_CF_SEC : flm_pkg::FLM_CF_NONE;
endmodule

// ### hw/flm_defs.svh
// flm register bank: register indices, field positions, address windows
// assumes every flm design file that uses its macros includes it by its bare name
`ifndef FLM_DEFS_SVH
`define FLM_DEFS_SVH
`define FLM_IX_CLKDIV 5'h00
`define FLM_IX_SEC 5'h01
`define FLM_IX_CMDIX 5'h02
`define FLM_IX_ECCIX 5'h03
`define FLM_IX_CNFG 5'h04
`define FLM_IX_ERCNFG 5'h05
`define FLM_IX_STAT 5'h06
`define FLM_IX_ERSTAT 5'h07
`define FLM_IX_PPROT 5'h08
`define FLM_IX_DPROT 5'h09
`define FLM_IX_CMDHI 5'h0A
`define FLM_IX_CMDLO 5'h0B
`define FLM_IX_RSV0 5'h0C
`define FLM_IX_RSV1 5'h0D
`define FLM_IX_ECCHI 5'h0E
`define FLM_IX_ECCLO 5'h0F
`define FLM_IX_OPT 5'h10
`define FLM_IX_RSV2 5'h11
`define FLM_IX_RSV3 5'h12
`define FLM_IX_RSV4 5'h13
`define FLM_ST_COMMAND_COMPLETE_FLAG 7
`define FLM_ST_ACCESS_ERROR 5
`define FLM_ST_PROTECTION_VIOLATION 4
`define FLM_ST_BUSY 3
`define FLM_PP_OPEN 7
`define FLM_PP_HDIS 5
`define FLM_PP_LDIS 2
`define FLM_DIV_LOADED 7
`define FLM_M_DIV 8'h7F
`define FLM_M_IX 8'h07
`define FLM_M_CNFG 8'h93
`define FLM_M_ERR 8'h03
`define FLM_M_PPROT 8'hBF
`define FLM_M_DPROT 8'h9F
`define FLM_SEC_DBL 8'hFF
`define FLM_MG_DBL 2'h3
`define FLM_PFL_BASE 23'h7E_0000
`define FLM_PFL_TOP 23'h7F_FFFF
`define FLM_LOW_BASE 23'h7F_8000
`define FLM_KEY_BASE 23'h7F_FF00
`define FLM_KEY_LAST 23'h7F_FF07
`define FLM_CFG_RSVL 23'h7F_FF0B
`define FLM_CFG_PPROT 23'h7F_FF0C
`define FLM_CFG_DPROT 23'h7F_FF0D
`define FLM_CFG_OPT 23'h7F_FF0E
`define FLM_CFG_SEC 23'h7F_FF0F
`define FLM_ID_BASE 23'h40_0000
`define FLM_ID_LAST 23'h40_0007
`define FLM_VER_BASE 23'h40_00E8
`define FLM_VER_LAST 23'h40_00E9
`define FLM_ONCE_BASE 23'h40_0100
`define FLM_ONCE_LAST 23'h40_013F
`define FLM_DFL_BASE 23'h10_0000
`define FLM_DFL_LAST 23'h10_1FFF
`define FLM_DIFR_BASE 23'h12_0000
`define FLM_DIFR_LAST 23'h12_007F
`define FLM_RAM_BASE 23'h12_3D00
`define FLM_RAM_LAST 23'h12_3FFF
`endif

// ### hw/flm_if.sv
// flm carriers between bank, reset loader and address decoder
// assumes one instance of each inside flm_regs_top
`timescale 1ns/1ns
interface flm_cfg_if;
  logic valid, dbl_fault, load, done;
  logic [7:0] sec_byte, opt_byte, sec, opt;
  modport seq (input valid, dbl_fault, sec_byte, opt_byte, output load, done, sec, opt);
  modport bank (output valid, dbl_fault, sec_byte, opt_byte, input load, done, sec, opt);
endinterface

interface flm_dec_if;
  flm_pkg::flm_gaddr_t addr;
  flm_pkg::flm_cfg_t field;
  logic write, pifr_vis, difr_vis, ram_vis;
  logic [2:0] prot_act;
  logic pfl, dfl, pifr, difr, ram, wr_en, prot_hit;
  modport dec (input addr, write, pifr_vis, difr_vis, ram_vis, prot_act,
    output field, pfl, dfl, pifr, difr, ram, wr_en, prot_hit);
  modport user (output addr, write, pifr_vis, difr_vis, ram_vis, prot_act,
    input field, pfl, dfl, pifr, difr, ram, wr_en, prot_hit);
endinterface

// ### hw/flm_pkg.sv
// flm shared types: reset sequence states, config byte codes
// assumes compilation before every flm file
package flm_pkg;
  typedef logic [22:0] flm_gaddr_t;
  typedef enum logic [2:0] {
    FLM_RST_HOLD = 3'h1,
    FLM_RST_LOAD = 3'h2,
    FLM_RST_DONE = 3'h4
  } flm_rst_t;
  typedef enum logic [2:0] {
    FLM_CF_NONE = 3'h0,
    FLM_CF_KEY = 3'h1,
    FLM_CF_RSVD = 3'h2,
    FLM_CF_PPROT = 3'h3,
    FLM_CF_DPROT = 3'h4,
    FLM_CF_OPT = 3'h5,
    FLM_CF_SEC = 3'h6
  } flm_cfg_t;
endpackage

// ### hw/flm_regs_top.sv
// flm top: apb register bank, reset loader and address decoder
// assumes an apb master on clk_sys and controller logic on clk_sys
`timescale 1ns/1ns
`include "flm_defs.svh"
module flm_regs_top #(
  parameter int CMD_DEPTH = 8,
  parameter int LOW_SIZE = 16384,
  parameter int HIGH_SIZE = 16384
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [6:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [22:0] mem_addr,
  input wire logic mem_write,
  input wire logic program_info_visible,
  input wire logic data_info_visible,
  input wire logic scratch_ram_visible,
  output logic pflash_sel,
  output logic dflash_sel,
  output logic pinfo_sel,
  output logic dinfo_sel,
  output logic scratch_sel,
  output logic [2:0] cfg_field,
  output logic mem_wr_en,
  output logic prot_hit,
  input wire logic cfg_valid,
  input wire logic cfg_dbl_fault,
  input wire logic [7:0] cfg_sec_byte,
  input wire logic [7:0] cfg_opt_byte,
  input wire logic [7:0] cfg_pprot_byte,
  input wire logic [7:0] cfg_dprot_byte,
  input wire logic cmd_done,
  input wire logic [1:0] cmd_status,
  input wire logic controller_busy,
  input wire logic access_error_set,
  input wire logic protection_violation_set,
  input wire logic single_fault_set,
  input wire logic double_fault_set,
  input wire logic [15:0] ecc_result,
  input wire logic [2:0] ctrl_index,
  output logic [15:0] ctrl_word,
  output logic cmd_launch,
  output logic [6:0] divider_value,
  output logic [7:0] module_config,
  output logic [7:0] error_irq_config,
  output logic [7:0] security_state,
  output logic [2:0] ecc_result_index
);
  initial begin
    if (CMD_DEPTH < 1 || CMD_DEPTH > 8)
      $error("command object depth must be 1 to 8");
  end

  flm_cfg_if cfg ();
  flm_dec_if dec ();

  logic [7:0] div_q, cnfg_q, ercnfg_q, pprot_q, dprot_q, rd_mux;
  logic [2:0] idx_q, eix_q;
  logic command_complete_flag_q, access_error_q, protection_violation_q, sfd_q, dfd_q, launch_q;
  logic [1:0] controller_status_q;
  logic [31:0] prdata_q;
  logic [15:0] cmd_obj_q [CMD_DEPTH];
  logic [15:0] ctrl_word_q;

  // apb phases, zero wait states
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire [4:0] ix = paddr[6:2];
  wire mapped = paddr[1:0] == 2'h0 && ix <= `FLM_IX_RSV4;
  wire wr = acc && pwrite && mapped;
  wire rd_setup = setup && !pwrite && mapped;
  wire [7:0] wd = pwdata[7:0];

  // per register write strobes
  wire wr_div = wr && ix == `FLM_IX_CLKDIV;
  wire wr_ix = wr && ix == `FLM_IX_CMDIX && command_complete_flag_q;
  wire wr_eix = wr && ix == `FLM_IX_ECCIX;
  wire wr_cnfg = wr && ix == `FLM_IX_CNFG;
  wire wr_ercnfg = wr && ix == `FLM_IX_ERCNFG;
  wire wr_stat = wr && ix == `FLM_IX_STAT;
  wire wr_erstat = wr && ix == `FLM_IX_ERSTAT;
  wire wr_pprot = wr && ix == `FLM_IX_PPROT;
  wire wr_dprot = wr && ix == `FLM_IX_DPROT;
  wire wr_hi = wr && ix == `FLM_IX_CMDHI && command_complete_flag_q;
  wire wr_lo = wr && ix == `FLM_IX_CMDLO && command_complete_flag_q;
  wire is_rsv = ix == `FLM_IX_RSV0 || ix == `FLM_IX_RSV1 || ix == `FLM_IX_RSV2
    || ix == `FLM_IX_RSV3 || ix == `FLM_IX_RSV4;

  // launch when software writes one to complete flag with no errors
  wire launch = wr_stat && wd[`FLM_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_q && !access_error_q && !protection_violation_q;
  wire clr_acc = wr_stat && wd[`FLM_ST_ACCESS_ERROR];
  wire clr_fpv = wr_stat && wd[`FLM_ST_PROTECTION_VIOLATION];
  wire [7:0] stat_rd = {command_complete_flag_q, 1'b0, access_error_q, protection_violation_q,
    controller_busy, 1'b0, controller_status_q};

  // read multiplexer, reserved and unmapped read zero
  always_comb begin
    rd_mux = 8'h00;
    case (ix)
      `FLM_IX_CLKDIV: rd_mux = div_q;
      `FLM_IX_SEC: rd_mux = cfg.sec;
      `FLM_IX_CMDIX: rd_mux = {5'h00, idx_q};
      `FLM_IX_ECCIX: rd_mux = {5'h00, eix_q};
      `FLM_IX_CNFG: rd_mux = cnfg_q;
      `FLM_IX_ERCNFG: rd_mux = ercnfg_q;
      `FLM_IX_STAT: rd_mux = stat_rd;
      `FLM_IX_ERSTAT: rd_mux = {6'h00, dfd_q, sfd_q};
      `FLM_IX_PPROT: rd_mux = pprot_q;
      `FLM_IX_DPROT: rd_mux = dprot_q;
      `FLM_IX_CMDHI: rd_mux = cmd_obj_q[idx_q][15:8];
      `FLM_IX_CMDLO: rd_mux = cmd_obj_q[idx_q][7:0];
      `FLM_IX_ECCHI: rd_mux = ecc_result[15:8];
      `FLM_IX_ECCLO: rd_mux = ecc_result[7:0];
      `FLM_IX_OPT: rd_mux = cfg.opt;
      default: rd_mux = 8'h00;
    endcase
  end

  // read data captured in setup, held through access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) prdata_q <= 32'h0000_0000;
    else if (setup) prdata_q <= rd_setup ? {24'h00_0000, rd_mux} : 32'h0000_0000;
  end

  // divider write once, loaded flag set by the write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) div_q <= 8'h00;
    else if (wr_div && !div_q[`FLM_DIV_LOADED]) div_q <= 8'h80 | (wd & `FLM_M_DIV);
  end

  // index and configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 3'h0;
      eix_q <= 3'h0;
      cnfg_q <= 8'h00;
      ercnfg_q <= 8'h00;
    end else begin
      if (wr_ix) idx_q <= wd[2:0];
      if (wr_eix) eix_q <= wd[2:0];
      if (wr_cnfg) cnfg_q <= wd & `FLM_M_CNFG;
      if (wr_ercnfg) ercnfg_q <= wd & `FLM_M_ERR;
    end
  end

  // protection bytes loaded at reset end, writable bits after
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pprot_q <= 8'h00;
      dprot_q <= 8'h00;
    end else if (cfg.load) begin
      pprot_q <= cfg_pprot_byte;
      dprot_q <= cfg_dprot_byte & `FLM_M_DPROT;
    end else begin
      if (wr_pprot) pprot_q <= (wd & `FLM_M_PPROT) | (pprot_q & ~`FLM_M_PPROT);
      if (wr_dprot) dprot_q <= wd & `FLM_M_DPROT;
    end
  end

  // status flags: set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      command_complete_flag_q <= 1'b0;
      access_error_q <= 1'b0;
      protection_violation_q <= 1'b0;
      sfd_q <= 1'b0;
      dfd_q <= 1'b0;
      controller_status_q <= 2'h0;
      launch_q <= 1'b0;
    end else begin
      if (cfg.load || cmd_done) command_complete_flag_q <= 1'b1;
      else if (launch) command_complete_flag_q <= 1'b0;
      access_error_q <= access_error_set || (access_error_q && !clr_acc);
      protection_violation_q <= protection_violation_set || (protection_violation_q && !clr_fpv);
      sfd_q <= single_fault_set || (sfd_q && !(wr_erstat && wd[0]));
      dfd_q <= double_fault_set || (dfd_q && !(wr_erstat && wd[1]));
      if (cfg.load) controller_status_q <= cfg_dbl_fault ? `FLM_MG_DBL : 2'h0;
      else if (cmd_done) controller_status_q <= cmd_status;
      else if (launch) controller_status_q <= 2'h0;
      launch_q <= launch;
    end
  end

  // command object entries, one per index
  genvar g;
  generate
    for (g = 0; g < CMD_DEPTH; g++) begin : g_obj
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) cmd_obj_q[g] <= 16'h0000;
        else if (idx_q == 3'(g)) begin
          if (wr_hi) cmd_obj_q[g][15:8] <= wd;
          if (wr_lo) cmd_obj_q[g][7:0] <= wd;
        end
      end
    end
  endgenerate

  // controller side read of the command object
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ctrl_word_q <= 16'h0000;
    else ctrl_word_q <= cmd_obj_q[ctrl_index];
  end

  // reset loader hookup
  assign cfg.valid = cfg_valid;
  assign cfg.dbl_fault = cfg_dbl_fault;
  assign cfg.sec_byte = cfg_sec_byte;
  assign cfg.opt_byte = cfg_opt_byte;
  flm_rst_seq u_rst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cfg(cfg)
  );

  // decoder hookup, regions active while their disable bit is clear
  assign dec.addr = mem_addr;
  assign dec.write = mem_write;
  assign dec.pifr_vis = program_info_visible;
  assign dec.difr_vis = data_info_visible;
  assign dec.ram_vis = scratch_ram_visible;
  assign dec.prot_act = {!pprot_q[`FLM_PP_OPEN], !pprot_q[`FLM_PP_HDIS],
    !pprot_q[`FLM_PP_LDIS]};
  flm_addr_dec #(
    .LOW_SIZE(LOW_SIZE),
    .HIGH_SIZE(HIGH_SIZE)
  ) u_dec (
    .d(dec)
  );

  // outputs
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign pflash_sel = dec.pfl;
  assign dflash_sel = dec.dfl;
  assign pinfo_sel = dec.pifr;
  assign dinfo_sel = dec.difr;
  assign scratch_sel = dec.ram;
  assign cfg_field = dec.field;
  assign mem_wr_en = dec.wr_en;
  assign prot_hit = dec.prot_hit;
  assign ctrl_word = ctrl_word_q;
  assign cmd_launch = launch_q;
  assign divider_value = div_q[6:0];
  assign module_config = cnfg_q;
  assign error_irq_config = ercnfg_q;
  assign security_state = cfg.sec;
  assign ecc_result_index = eix_q;

  // checks on the bus, loader, status flag and decoder selects
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [4:0] i);
    setup && !pwrite && mapped && ix == i ##1 acc;
  endsequence
  sequence s_wr(logic [4:0] i);
    setup && pwrite && mapped && ix == i ##1 acc;
  endsequence
  sequence s_hold_fault;
    cfg_valid && cfg_dbl_fault && !cfg.load && !cfg.done;
  endsequence

  AST_RSV_ZERO: assert property ((rd_setup && is_rsv ##1 acc) |-> prdata == 32'h0000_0000)
    else $error("reserved register read not zero");
  AST_UNMAP: assert property ((setup && !mapped ##1 acc) |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_IX_UPPER: assert property (s_rd(`FLM_IX_CMDIX) |-> prdata[31:3] == 29'h0)
    else $error("command index upper bits set");
  AST_EIX_UPPER: assert property (s_rd(`FLM_IX_ECCIX) |-> prdata[31:3] == 29'h0)
    else $error("ecc index upper bits set");
  AST_SEC_RO: assert property ((s_wr(`FLM_IX_SEC) ##0 cfg.done) |=> $stable(security_state))
    else $error("security register changed by write");
  AST_COMMAND_COMPLETE_FLAG_RST: assert property (!cfg.done |-> !command_complete_flag_q)
    else $error("complete flag set during reset sequence");
  AST_IX_BLOCK: assert property ((s_wr(`FLM_IX_CMDIX) ##0 !command_complete_flag_q) |=> $stable(idx_q))
    else $error("index written while command active");
  AST_CMD_HI: assert property ((s_wr(`FLM_IX_CMDHI) ##0 command_complete_flag_q) |=>
    cmd_obj_q[idx_q][15:8] == $past(pwdata[7:0]))
    else $error("command high byte not stored");
  AST_FPV_SET: assert property (protection_violation_set |=> protection_violation_q && stat_rd[4])
    else $error("violation flag not set");
  AST_DINFO_HIDE: assert property (!data_info_visible |-> !dinfo_sel)
    else $error("data info window selected while hidden");
  AST_RAM_HIDE: assert property (!scratch_ram_visible |-> !scratch_sel && !mem_wr_en
    || pflash_sel || dflash_sel || pinfo_sel || dinfo_sel)
    else $error("scratch ram selected while hidden");
  AST_DBL_SEC: assert property (s_hold_fault |-> ##2 cfg.done && command_complete_flag_q
    && security_state == `FLM_SEC_DBL && controller_status_q == `FLM_MG_DBL)
    else $error("double fault did not secure the part");
endmodule

// ### hw/flm_rst_seq.sv
// flm reset loader: captures config phrase bytes, then marks completion
// assumes the array reader pulses valid once after reset
`timescale 1ns/1ns
`include "flm_defs.svh"
module flm_rst_seq (
  input wire logic clk_sys,
  input wire logic rst_n,
  flm_cfg_if.seq cfg
);
  flm_pkg::flm_rst_t state_q, state_d;
  logic [7:0] sec_q, opt_q;

  // hold until phrase arrives, one load cycle, then done
  always_comb begin
    state_d = state_q;
    case (state_q)
      flm_pkg::FLM_RST_HOLD: if (cfg.valid) state_d = flm_pkg::FLM_RST_LOAD;
      flm_pkg::FLM_RST_LOAD: state_d = flm_pkg::FLM_RST_DONE;
      flm_pkg::FLM_RST_DONE: state_d = flm_pkg::FLM_RST_DONE;
      default: state_d = flm_pkg::FLM_RST_HOLD;
    endcase
  end

  // security byte or all ones on double fault
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= flm_pkg::FLM_RST_HOLD;
      sec_q <= `FLM_SEC_DBL;
      opt_q <= `FLM_SEC_DBL;
    end else begin
      state_q <= state_d;
      if (state_q == flm_pkg::FLM_RST_HOLD && cfg.valid) begin
        sec_q <= cfg.dbl_fault ? `FLM_SEC_DBL : cfg.sec_byte;
        opt_q <= cfg.opt_byte;
      end
    end
  end

  assign cfg.load = (state_q == flm_pkg::FLM_RST_LOAD);
  assign cfg.done = (state_q == flm_pkg::FLM_RST_DONE);
  assign cfg.sec = sec_q;
  assign cfg.opt = opt_q;
endmodule

// ### tb/flm_array_model.sv
// flm array model: config phrase reader and command controller stand-in
// assumes flm_regs_top on the same clk_sys and rst_n
`timescale 1ns/1ns
module flm_array_model #(
  parameter logic [7:0] SEC_V = 8'hA5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dbl,
  input wire logic cmd_launch,
  output logic cfg_valid,
  output logic cfg_dbl_fault,
  output logic [7:0] cfg_sec_byte,
  output logic [7:0] cfg_opt_byte,
  output logic [7:0] cfg_pprot_byte,
  output logic [7:0] cfg_dprot_byte,
  output logic cmd_done,
  output logic [1:0] cmd_status
);
  logic [3:0] cnt_q;
  logic [3:0] run_q;
  logic hold;
  // phrase bytes shown in the valid cycle and one after, inverted otherwise
  assign hold = (cnt_q == 4'h8) || (cnt_q == 4'h9);
  assign cfg_sec_byte = hold ? SEC_V : ~SEC_V;
  assign cfg_opt_byte = hold ? 8'h3C : 8'hC3;
  assign cfg_pprot_byte = hold ? 8'hFF : 8'h00;
  assign cfg_dprot_byte = hold ? 8'hFF : 8'h00;
  assign cfg_dbl_fault = hold & dbl;
  assign cmd_status = cmd_done ? 2'h2 : 2'h1;
  // one phrase read after reset, commands finish five cycles after launch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      run_q <= 4'h0;
      cfg_valid <= 1'b0;
      cmd_done <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
      cfg_valid <= (cnt_q == 4'h7);
      run_q <= {run_q[2:0], cmd_launch};
      cmd_done <= run_q[3];
    end
  end
endmodule

// ### tb/flm_regs_top_tb.sv
// flm bench: apb register checks, decode table, reset and command cases
// assumes flm_pkg, flm_if and the flm design files compiled first
`timescale 1ns/1ns
module flm_regs_top_tb;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, vis, dbl, busy, pv_set;
  logic pflash_sel, dflash_sel, pinfo_sel, dinfo_sel, scratch_sel, mem_wr_en, cmd_launch;
  logic cfg_valid, cfg_dbl_fault, cmd_done;
  logic mwr, prot_hit;
  logic [1:0] cmd_status;
  logic [2:0] cfg_field;
  logic [6:0] paddr;
  logic [7:0] sec_b, opt_b, pp_b, dp_b;
  logic [22:0] mem_addr;
  logic [31:0] pwdata, prdata, rd;
  int n_errors = 0;
  int compares = 0;
  // addr, visible, selects {pfl,dfl,pinfo,dinfo,ram}, config field
  logic [31:0] dt [18] = '{{23'h7E_0000, 1'b0, 5'h10, 3'h0}, {23'h7F_FFFF, 1'b0, 5'h10, 3'h0},
    {23'h7F_FF00, 1'b0, 5'h10, 3'h1}, {23'h7F_FF08, 1'b0, 5'h10, 3'h2},
    {23'h7F_FF0C, 1'b0, 5'h10, 3'h3}, {23'h7F_FF0D, 1'b0, 5'h10, 3'h4},
    {23'h7F_FF0E, 1'b0, 5'h10, 3'h5}, {23'h7F_FF0F, 1'b0, 5'h10, 3'h6},
    {23'h10_1FFF, 1'b0, 5'h08, 3'h0}, {23'h10_2000, 1'b1, 5'h00, 3'h0},
    {23'h40_00E8, 1'b1, 5'h04, 3'h0}, {23'h40_013F, 1'b1, 5'h04, 3'h0},
    {23'h40_0008, 1'b1, 5'h00, 3'h0}, {23'h40_0000, 1'b0, 5'h00, 3'h0},
    {23'h12_007F, 1'b1, 5'h02, 3'h0}, {23'h12_0000, 1'b0, 5'h00, 3'h0},
    {23'h12_3D00, 1'b1, 5'h01, 3'h0}, {23'h12_3FFF, 1'b0, 5'h00, 3'h0}};
  // index, write data, read back
  logic [23:0] rt [20] = '{24'h02_FF07, 24'h03_FF07, 24'h0A_5A5A, 24'h0B_C3C3, 24'h0C_FF00,
    24'h0D_FF00, 24'h11_FF00, 24'h12_FF00, 24'h13_FF00, 24'h01_00A5, 24'h0E_00BE,
    24'h0F_00EF, 24'h10_003C, 24'h14_FF00, 24'h1F_FF00, 24'h00_1292, 24'h00_FF92,
    24'h04_FF93, 24'h05_FF03, 24'h09_FF9F};
  flm_regs_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_addr(mem_addr), .mem_write(mwr), .program_info_visible(vis),
    .data_info_visible(vis), .scratch_ram_visible(vis), .pflash_sel(pflash_sel),
    .dflash_sel(dflash_sel), .pinfo_sel(pinfo_sel), .dinfo_sel(dinfo_sel),
    .scratch_sel(scratch_sel), .cfg_field(cfg_field), .mem_wr_en(mem_wr_en),
    .prot_hit(prot_hit),
    .cfg_valid(cfg_valid), .cfg_dbl_fault(cfg_dbl_fault), .cfg_sec_byte(sec_b),
    .cfg_opt_byte(opt_b), .cfg_pprot_byte(pp_b), .cfg_dprot_byte(dp_b), .cmd_done(cmd_done),
    .cmd_status(cmd_status), .controller_busy(busy), .access_error_set(1'b0),
    .protection_violation_set(pv_set), .single_fault_set(1'b0), .double_fault_set(1'b0),
    .ecc_result(16'hBEEF), .ctrl_index(3'h0), .ctrl_word(), .cmd_launch(cmd_launch),
    .divider_value(), .module_config(), .error_irq_config(), .security_state(),
    .ecc_result_index());
  flm_array_model i_arr (.clk_sys(clk_sys), .rst_n(rst_n), .dbl(dbl), .cmd_launch(cmd_launch),
    .cfg_valid(cfg_valid), .cfg_dbl_fault(cfg_dbl_fault), .cfg_sec_byte(sec_b),
    .cfg_opt_byte(opt_b), .cfg_pprot_byte(pp_b), .cfg_dprot_byte(dp_b), .cmd_done(cmd_done),
    .cmd_status(cmd_status));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // counts and verdict
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // value compare
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    compares++;
    if (act !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [4:0] ix, input logic [7:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic rdchk(input logic [4:0] ix, input logic [31:0] exp);
    apb(1'b0, ix, 8'h00);
    chk(rd, exp);
  endtask
  // poll status until the complete flag is up
  task automatic wait_command_complete_flag();
    int n;
    for (n = 0; n < 40; n++) begin
      apb(1'b0, 5'h06, 8'h00);
      if (rd[7] === 1'b1) break;
    end
    if (n == 40) begin
      n_errors++;
      close_out();
    end
  endtask
  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, vis, dbl, busy, pv_set} = 8'h00;
    paddr = 7'h00;
    pwdata = 32'h0;
    mem_addr = 23'h0;
    mwr = 1'b1;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(5'h06, 32'h0);
    apb(1'b1, 5'h02, 8'h05);
    wait_command_complete_flag();
    rdchk(5'h02, 32'h0);
    rdchk(5'h06, 32'h80);
    for (int i = 0; i < 20; i++) begin
      apb(1'b1, rt[i][20:16], rt[i][15:8]);
      rdchk(rt[i][20:16], {24'h0, rt[i][7:0]});
    end
    for (int i = 0; i < 18; i++) begin
      @(posedge clk_sys);
      mem_addr <= dt[i][31:9];
      vis <= dt[i][8];
      @(negedge clk_sys);
      chk({23'h0, pflash_sel, dflash_sel, pinfo_sel, dinfo_sel, scratch_sel, cfg_field,
        mem_wr_en}, {23'h0, dt[i][7:0], |dt[i][7:3]});
    end
    // only the lower region armed: hit there, none in the remaining region, none on reads
    apb(1'b1, 5'h08, 8'hFB);
    rdchk(5'h08, 32'hFB);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      mem_addr <= (i == 1) ? 23'h7E_0000 : 23'h7F_8000;
      mwr <= (i != 2);
      @(negedge clk_sys);
      chk({30'h0, prot_hit, mem_wr_en}, {30'h0, i == 0, i != 2});
    end
    apb(1'b1, 5'h06, 8'h80);
    repeat (2) @(posedge clk_sys);
    wait_command_complete_flag();
    rdchk(5'h06, 32'h82);
    @(posedge clk_sys);
    pv_set <= 1'b1;
    busy <= 1'b1;
    @(posedge clk_sys);
    pv_set <= 1'b0;
    rdchk(5'h06, 32'h9A);
    apb(1'b1, 5'h06, 8'h10);
    @(posedge clk_sys);
    busy <= 1'b0;
    rdchk(5'h06, 32'h82);
    dbl <= 1'b1;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_command_complete_flag();
    rdchk(5'h01, 32'hFF);
    rdchk(5'h06, 32'h83);
    close_out();
  end
endmodule
